// >>> inc/rcs_pkg.sv
// constants for the reset cause and software reset block
`default_nettype none
package rcs_pkg;
	localparam logic [15:0] CAUSE_OFS    = 16'hF600;
	localparam logic [15:0] TRIG_OFS     = 16'hF610;
	localparam logic [15:0] IRQ_STAT_OFS = 16'hF620;
	localparam logic [15:0] IRQ_MASK_OFS = 16'hF630;
	localparam int HVR_BIT   = 29;
	localparam int CMR_BIT   = 9;
	localparam int VSTBY_BIT = 8;
	localparam int EXT_BIT   = 7;
	localparam int SWF_BIT   = 6;
	localparam int WDT_BIT   = 4;
	localparam int SLP_BIT   = 3;
	localparam int IDL_BIT   = 2;
	localparam int BRN_BIT   = 1;
	localparam int PWR_BIT   = 0;
	localparam int GO_BIT    = 0;
	// implemented flag bits (hardware set, software clear)
	localparam logic [31:0] FLAG_MASK  = 32'h200002DF;
	localparam logic [31:0] CAUSE_RST  = 32'h00000003;
	localparam logic [31:0] ZERO_WORD  = 32'h00000000;
	localparam logic [1:0]  HTRANS_NSQ = 2'h2;
	// cycles the master system reset pulse is held
	localparam int MASTER_SYSTEM_RESET_CYCLES = 4;
endpackage
`default_nettype wire

// >>> core/rcs_reset_cause.sv
// reset cause register, software reset trigger and reset combiner
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
module rcs_reset_cause (
	input  wire logic        ref_clk,        // system clock
	input  wire logic        resetn,         // synchronous reset, low
	input  wire logic        hsel,           // ahb select
	input  wire logic [31:0] haddr,          // ahb address
	input  wire logic [1:0]  htrans,         // ahb transfer type
	input  wire logic        hwrite,         // ahb write
	input  wire logic [2:0]  hsize,          // ahb size
	input  wire logic [31:0] hwdata,         // ahb write data
	input  wire logic        hready,         // ahb bus ready
	output logic [31:0]      hrdata,         // ahb read data
	output logic             hreadyout,      // ahb slave ready
	output logic             hresp,          // ahb response
	input  wire logic        pwrOnEvt,       // power-on detected
	input  wire logic        extPinEvt,      // external reset pin
	input  wire logic        wdtEvt,         // watchdog timeout
	input  wire logic        brownEvt,       // brown-out
	input  wire logic        cfgMismatchEvt, // config mismatch
	input  wire logic        highVoltEvt,    // high voltage detect
	input  wire logic        sleepWake,      // wake from sleep
	input  wire logic        idleWake,       // wake from idle
	input  wire logic        unlocked,       // unlock sequence done
	output logic             masterSysRst,   // master system reset
	output logic             regStandbyCtrl, // regulator on in sleep
	output logic             irq             // level interrupt
);
	logic [31:0] causeReg, causeNext;
	logic [31:0] statReg, statNext;
	logic [31:0] maskReg;
	logic        goReg;
	logic [2:0]  rstCntReg;
	logic        wrPendReg, rdPendReg;
	logic [15:0] addrReg;
	logic [31:0] rdataNext;
	logic        irqNext;

	// every check below runs on the system clock, held off in reset
	default clocking cbSys @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// pins pass two flops before logic reads them
	logic [7:0] syncA, syncB, syncC;
	wire  [7:0] rawEvt = {idleWake, sleepWake, highVoltEvt, cfgMismatchEvt,
		brownEvt, wdtEvt, extPinEvt, pwrOnEvt};
	always_ff @(posedge ref_clk) begin
		syncA <= rawEvt;
		syncB <= syncA;
		syncC <= syncB;
	end
	// rising edge: one event, one set
	wire [7:0] evtRise = syncB & ~syncC;

	wire addrPhase = hsel & hready & (htrans == rcs_pkg::HTRANS_NSQ);
	wire wrCause = wrPendReg & (addrReg == rcs_pkg::CAUSE_OFS);
	wire wrTrig  = wrPendReg & (addrReg == rcs_pkg::TRIG_OFS);
	wire wrStat  = wrPendReg & (addrReg == rcs_pkg::IRQ_STAT_OFS);
	wire wrMask  = wrPendReg & (addrReg == rcs_pkg::IRQ_MASK_OFS);
	wire rdNow   = addrPhase & ~hwrite;
	wire [15:0] rdAddr = haddr[15:0];

	// trigger honoured only with unlock done and bit 0 set
	wire goAccept = wrTrig & unlocked & hwdata[rcs_pkg::GO_BIT];
	wire swEvt    = goReg;

	wire [31:0] hwSet;
	assign hwSet[rcs_pkg::HVR_BIT] = evtRise[5];
	assign hwSet[rcs_pkg::CMR_BIT] = evtRise[4];
	assign hwSet[rcs_pkg::EXT_BIT] = evtRise[1];
	assign hwSet[rcs_pkg::SWF_BIT] = swEvt;
	assign hwSet[rcs_pkg::WDT_BIT] = evtRise[2];
	assign hwSet[rcs_pkg::SLP_BIT] = evtRise[6];
	assign hwSet[rcs_pkg::IDL_BIT] = evtRise[7];
	assign hwSet[rcs_pkg::BRN_BIT] = evtRise[3];
	assign hwSet[rcs_pkg::PWR_BIT] = evtRise[0];
	assign hwSet[31:30] = 2'h0;
	assign hwSet[28:10] = 19'h0;
	assign hwSet[rcs_pkg::VSTBY_BIT] = 1'b0;
	assign hwSet[5] = 1'b0;

	// flags: software may only clear them; writes of one hold value
	wire [31:0] swKeep = wrCause ? (causeReg & hwdata) : causeReg;
	always_comb begin
		causeNext = ((swKeep | hwSet) & rcs_pkg::FLAG_MASK);
		causeNext[rcs_pkg::VSTBY_BIT] = wrCause ?
			hwdata[rcs_pkg::VSTBY_BIT] : causeReg[rcs_pkg::VSTBY_BIT];
	end

	// interrupt status: write one clears, set still wins
	always_comb begin
		statNext = statReg;
		if (wrStat) begin
			statNext = statReg & ~hwdata;
		end
		statNext = (statNext | hwSet) & rcs_pkg::FLAG_MASK;
	end
	assign irqNext = |(statNext & maskReg);

	assign rdataNext =
		(rdAddr == rcs_pkg::CAUSE_OFS)    ? causeNext :
		(rdAddr == rcs_pkg::IRQ_STAT_OFS) ? statNext :
		(rdAddr == rcs_pkg::IRQ_MASK_OFS) ? maskReg :
		rcs_pkg::ZERO_WORD; // trigger reads zero

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			// power-on leaves both supply flags standing
			causeReg <= rcs_pkg::CAUSE_RST;
			statReg  <= rcs_pkg::ZERO_WORD;
			maskReg  <= rcs_pkg::ZERO_WORD;
			goReg    <= 1'b0;
		end else begin
			causeReg <= causeNext;
			statReg  <= statNext;
			if (wrMask) begin
				maskReg <= hwdata & rcs_pkg::FLAG_MASK;
			end
			goReg <= goAccept; // self clears next cycle
		end
	end

	// master reset stretched so every source gives a clean pulse
	wire anySrc = swEvt | (|evtRise[5:0]);
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rstCntReg    <= 3'h0;
			masterSysRst <= 1'b0;
		end else begin
			if (anySrc) begin
				rstCntReg <= 3'(rcs_pkg::MASTER_SYSTEM_RESET_CYCLES);
			end else if (rstCntReg != 3'h0) begin
				rstCntReg <= rstCntReg - 3'h1;
			end
			masterSysRst <= anySrc | (rstCntReg > 3'h1);
		end
	end

	// zero wait state slave; read data registered from address phase
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wrPendReg      <= 1'b0;
			rdPendReg      <= 1'b0;
			addrReg        <= 16'h0000;
			hrdata         <= rcs_pkg::ZERO_WORD;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			regStandbyCtrl <= 1'b0;
			irq            <= 1'b0;
		end else begin
			wrPendReg      <= addrPhase & hwrite;
			rdPendReg      <= rdNow;
			addrReg        <= haddr[15:0];
			hrdata         <= rdNow ? rdataNext : rcs_pkg::ZERO_WORD;
			hreadyout      <= 1'b1;
			hresp          <= 1'b0;
			regStandbyCtrl <= causeNext[rcs_pkg::VSTBY_BIT];
			irq            <= irqNext;
		end
	end

	// trigger write that passes the lock and carries a one in bit 0
	sequence s_go_write;
		wrTrig && unlocked && hwdata[rcs_pkg::GO_BIT];
	endsequence

	// four cycles in a row with no reset source at all
	sequence s_src_quiet;
		!anySrc [*4];
	endsequence

	// software trigger path
	a_sw_go_flag: assert property (
		goAccept |=> ##1 causeReg[rcs_pkg::SWF_BIT])
		else $error("software flag not set after trigger");

	a_locked_write: assert property (
		(wrTrig && !unlocked) |=> !goReg)
		else $error("locked trigger write accepted");

	a_go_clears: assert property (
		goReg |=> !goReg || $past(goAccept))
		else $error("trigger bit did not self clear");

	a_go_needs_unlock: assert property (
		goReg |-> $past(wrTrig && unlocked))
		else $error("trigger fired without unlock");

	a_zero_go: assert property (
		(wrTrig && !hwdata[rcs_pkg::GO_BIT]) |=> !goReg)
		else $error("zero write fired trigger");

	a_go_accept: assert property (
		s_go_write |=> goReg)
		else $error("accepted trigger write lost");

	a_go_resets: assert property (
		s_go_write |=> ##1 masterSysRst)
		else $error("trigger did not reset system");

	// cause flags
	a_unimpl_zero: assert property (
		(causeReg & ~(rcs_pkg::FLAG_MASK | 32'h00000100)) == 32'h0)
		else $error("unimplemented cause bit set");

	a_flag_sticky: assert property (
		(causeReg[rcs_pkg::WDT_BIT] && !wrCause) |=>
		causeReg[rcs_pkg::WDT_BIT])
		else $error("flag cleared without software write");

	a_flag_no_drop: assert property (
		!wrCause |=> (($past(causeReg) & ~causeReg &
		rcs_pkg::FLAG_MASK) == rcs_pkg::ZERO_WORD))
		else $error("cause flag fell without write");

	a_no_spur_set: assert property (
		1'b1 |=> ((~$past(causeReg) & causeReg & rcs_pkg::FLAG_MASK &
		~$past(hwSet)) == rcs_pkg::ZERO_WORD))
		else $error("cause flag rose without event");

	a_cause_clear: assert property (
		(wrCause && !hwdata[rcs_pkg::WDT_BIT] &&
		!hwSet[rcs_pkg::WDT_BIT]) |=> !causeReg[rcs_pkg::WDT_BIT])
		else $error("zero write did not clear flag");

	a_set_wins: assert property (
		hwSet[rcs_pkg::EXT_BIT] |=> causeReg[rcs_pkg::EXT_BIT])
		else $error("hardware set lost");

	a_hvr_sets: assert property (
		evtRise[5] |=> causeReg[rcs_pkg::HVR_BIT])
		else $error("high voltage flag not set");

	a_cmr_sets: assert property (
		evtRise[4] |=> causeReg[rcs_pkg::CMR_BIT])
		else $error("mismatch flag not set");

	a_ext_sets: assert property (
		evtRise[1] |=> causeReg[rcs_pkg::EXT_BIT])
		else $error("external pin flag not set");

	a_swf_sets: assert property (
		swEvt |=> causeReg[rcs_pkg::SWF_BIT])
		else $error("software flag not set");

	a_wdt_sets: assert property (
		evtRise[2] |=> causeReg[rcs_pkg::WDT_BIT])
		else $error("watchdog flag not set");

	a_slp_sets: assert property (
		evtRise[6] |=> causeReg[rcs_pkg::SLP_BIT])
		else $error("sleep wake flag not set");

	a_idl_sets: assert property (
		evtRise[7] |=> causeReg[rcs_pkg::IDL_BIT])
		else $error("idle wake flag not set");

	a_brn_sets: assert property (
		evtRise[3] |=> causeReg[rcs_pkg::BRN_BIT])
		else $error("brown-out flag not set");

	a_pwr_sets: assert property (
		evtRise[0] |=> causeReg[rcs_pkg::PWR_BIT])
		else $error("power-on flag not set");

	// regulator standby control
	a_standby_wr: assert property (
		wrCause |=> causeReg[rcs_pkg::VSTBY_BIT] ==
		$past(hwdata[rcs_pkg::VSTBY_BIT]))
		else $error("standby control not written");

	a_std_keep: assert property (
		!wrCause |=> causeReg[rcs_pkg::VSTBY_BIT] ==
		$past(causeReg[rcs_pkg::VSTBY_BIT]))
		else $error("standby control changed unasked");

	a_std_pin: assert property (
		regStandbyCtrl == causeReg[rcs_pkg::VSTBY_BIT])
		else $error("standby pin differs from register");

	// master system reset
	a_reset_pulse: assert property (
		anySrc |=> masterSysRst [*3])
		else $error("master reset pulse too short");

	a_src_reset: assert property (
		(|evtRise[5:0]) |=> masterSysRst)
		else $error("source did not raise master reset");

	a_rst_ends: assert property (
		s_src_quiet |=> !masterSysRst)
		else $error("master reset held too long");

	a_cnt_bound: assert property (
		rstCntReg <= 3'(rcs_pkg::MASTER_SYSTEM_RESET_CYCLES))
		else $error("reset counter out of range");

	// interrupt status and mask
	a_stat_set: assert property (
		hwSet[rcs_pkg::EXT_BIT] |=> statReg[rcs_pkg::EXT_BIT])
		else $error("status set lost");

	a_stat_clear: assert property (
		(wrStat && hwdata[rcs_pkg::EXT_BIT] &&
		!hwSet[rcs_pkg::EXT_BIT]) |=> !statReg[rcs_pkg::EXT_BIT])
		else $error("status bit not cleared by one");

	a_stat_sticky: assert property (
		!wrStat |=> (($past(statReg) & ~statReg) ==
		rcs_pkg::ZERO_WORD))
		else $error("status bit fell without write");

	a_stat_unimpl: assert property (
		(statReg & ~rcs_pkg::FLAG_MASK) == rcs_pkg::ZERO_WORD)
		else $error("unimplemented status bit set");

	a_mask_unimpl: assert property (
		(maskReg & ~rcs_pkg::FLAG_MASK) == rcs_pkg::ZERO_WORD)
		else $error("unimplemented mask bit set");

	a_mask_wr: assert property (
		wrMask |=> maskReg == ($past(hwdata) & rcs_pkg::FLAG_MASK))
		else $error("mask write lost");

	a_irq_level: assert property (
		1'b1 |=> (irq == (|($past(statNext) & $past(maskReg)))))
		else $error("interrupt level wrong");

	a_irq_off: assert property (
		(maskReg == rcs_pkg::ZERO_WORD) |=> !irq)
		else $error("masked interrupt raised");

	// register bus
	a_ready_high: assert property (
		hreadyout)
		else $error("slave inserted a wait state");

	a_resp_okay: assert property (
		!hresp)
		else $error("slave response not okay");

	a_wr_pend: assert property (
		(addrPhase && hwrite) |=> wrPendReg)
		else $error("write address phase lost");

	a_no_wr: assert property (
		!(addrPhase && hwrite) |=> !wrPendReg)
		else $error("spurious write data phase");

	a_rd_pend: assert property (
		rdNow |=> rdPendReg)
		else $error("read address phase lost");

	a_rdata_idle: assert property (
		!rdPendReg |-> hrdata == rcs_pkg::ZERO_WORD)
		else $error("read data outside data phase");

	a_rdata_cause: assert property (
		(rdNow && rdAddr == rcs_pkg::CAUSE_OFS) |=>
		hrdata == $past(causeNext))
		else $error("cause read data wrong");

	a_rdata_stat: assert property (
		(rdNow && rdAddr == rcs_pkg::IRQ_STAT_OFS) |=>
		hrdata == $past(statNext))
		else $error("status read data wrong");

	a_rdata_mask: assert property (
		(rdNow && rdAddr == rcs_pkg::IRQ_MASK_OFS) |=>
		hrdata == $past(maskReg))
		else $error("mask read data wrong");

	a_rdata_unmap: assert property (
		(rdNow && rdAddr != rcs_pkg::CAUSE_OFS &&
		rdAddr != rcs_pkg::IRQ_STAT_OFS &&
		rdAddr != rcs_pkg::IRQ_MASK_OFS) |=>
		hrdata == rcs_pkg::ZERO_WORD)
		else $error("unmapped or trigger read not zero");
endmodule
`default_nettype wire

// >>> test/reset_cause_and_soft_reset_tb.sv
// self-checking testbench for the reset cause and software reset block
`default_nettype none
module reset_cause_and_soft_reset_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        refClk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic        unlocked = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, ex;
	logic [1:0]  htrans = 2'h0;
	logic [7:0]  evt = 8'h00;
	logic        hreadyout, hresp, masterSysRst, regStandbyCtrl, irq;
	int          errTotal = 0, compares = 0, rstCnt = 0, rstBase = 0;
	int          eb[8] = '{rcs_pkg::PWR_BIT, rcs_pkg::EXT_BIT,
		rcs_pkg::WDT_BIT, rcs_pkg::BRN_BIT, rcs_pkg::CMR_BIT,
		rcs_pkg::HVR_BIT, rcs_pkg::SLP_BIT, rcs_pkg::IDL_BIT};

	rcs_reset_cause i_rcs_reset_cause (
		.ref_clk(refClk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pwrOnEvt(evt[0]), .extPinEvt(evt[1]),
		.wdtEvt(evt[2]), .brownEvt(evt[3]), .cfgMismatchEvt(evt[4]),
		.highVoltEvt(evt[5]), .sleepWake(evt[6]), .idleWake(evt[7]),
		.unlocked(unlocked), .masterSysRst(masterSysRst),
		.regStandbyCtrl(regStandbyCtrl), .irq(irq));

	initial begin
		forever #4 refClk = ~refClk;
	end
	// sticky so a short reset pulse is never missed between checks
	always @(posedge refClk) begin
		if (masterSysRst === 1'b1) rstCnt <= rstCnt + 1;
	end

	task automatic check(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finishTest();
		$display("comparisons %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge refClk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			errTotal++;
			finishTest();
		end
	endtask
	task automatic bus(input logic [15:0] a, input logic wr,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= rcs_pkg::HTRANS_NSQ;
		haddr <= {16'h0000, a};
		hwrite <= wr;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		q = hrdata;
		check("hresp okay", {31'h0, hresp}, 32'h0);
	endtask
	task automatic rdChk(input string nm, input logic [15:0] a,
		input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		check(nm, q, e);
	endtask
	// flag lands three edges after the rise, so six edges is ample
	task automatic pulse(input int i);
		evt[i] <= 1'b1;
		repeat (2) @(posedge refClk);
		evt[i] <= 1'b0;
		repeat (4) @(posedge refClk);
	endtask

	task automatic testReset();
		rdChk("cause reset", rcs_pkg::CAUSE_OFS, rcs_pkg::CAUSE_RST);
		rdChk("trigger reset", rcs_pkg::TRIG_OFS, 32'h0);
		rdChk("unmapped", 16'hF640, 32'h0);
		check("standby reset", {31'h0, regStandbyCtrl}, 32'h0);
		$display("reset test done");
	endtask
	task automatic testFlags();
		bus(rcs_pkg::CAUSE_OFS, 1'b1, 32'h0);
		rdChk("cause cleared", rcs_pkg::CAUSE_OFS, 32'h0);
		ex = 32'h0;
		for (int i = 0; i < 8; i++) begin
			rstBase = rstCnt;
			pulse(i);
			ex[eb[i]] = 1'b1;
			rdChk("cause flag", rcs_pkg::CAUSE_OFS, ex);
			check("source reset", {31'h0, rstCnt != rstBase},
				32'(i < 6));
		end
		bus(rcs_pkg::CAUSE_OFS, 1'b1, 32'hFFFFFFFF);
		ex[rcs_pkg::VSTBY_BIT] = 1'b1;
		rdChk("cause ones", rcs_pkg::CAUSE_OFS, ex);
		check("standby pin", {31'h0, regStandbyCtrl}, 32'h1);
		$display("flag test done");
	endtask
	task automatic testTrig();
		rstBase = rstCnt;
		bus(rcs_pkg::TRIG_OFS, 1'b1, 32'h00000001);
		repeat (8) @(posedge refClk);
		check("locked go", {31'h0, rstCnt != rstBase}, 32'h0);
		unlocked <= 1'b1;
		bus(rcs_pkg::TRIG_OFS, 1'b1, 32'hFFFFFFFE);
		repeat (8) @(posedge refClk);
		check("zero go", {31'h0, rstCnt != rstBase}, 32'h0);
		bus(rcs_pkg::TRIG_OFS, 1'b1, 32'h00000001);
		repeat (8) @(posedge refClk);
		check("go reset", {31'h0, rstCnt != rstBase}, 32'h1);
		ex[rcs_pkg::SWF_BIT] = 1'b1;
		rdChk("software flag", rcs_pkg::CAUSE_OFS, ex);
		rdChk("go cleared", rcs_pkg::TRIG_OFS, 32'h0);
		unlocked <= 1'b0;
		$display("trigger test done");
	endtask
	task automatic irqStep(input logic [15:0] a, input logic [31:0] d,
		input logic e);
		bus(a, 1'b1, d);
		repeat (2) @(posedge refClk);
		check("irq level", {31'h0, irq}, {31'h0, e});
	endtask
	task automatic testIrq();
		irqStep(rcs_pkg::IRQ_STAT_OFS, 32'hFFFFFFFF, 1'b0);
		irqStep(rcs_pkg::IRQ_MASK_OFS, 32'h00000080, 1'b0);
		pulse(1);
		check("irq raised", {31'h0, irq}, 32'h1);
		irqStep(rcs_pkg::IRQ_MASK_OFS, 32'h0, 1'b0);
		irqStep(rcs_pkg::IRQ_MASK_OFS, 32'h00000080, 1'b1);
		irqStep(rcs_pkg::IRQ_STAT_OFS, 32'h00000080, 1'b0);
		rdChk("irq status", rcs_pkg::IRQ_STAT_OFS, 32'h0);
		$display("interrupt test done");
	endtask

	initial begin
		repeat (8) @(posedge refClk);
		resetn <= 1'b1;
		@(posedge refClk);
		testReset();
		testFlags();
		testTrig();
		testIrq();
		finishTest();
	end
endmodule
`default_nettype wire
